// ==== hdl/chd_pkg.sv ====
/*
 * constants shared by the decimation chain: register map, field layout,
 * reset values, accumulator widths and halfband coefficients.
 * assumes 32-bit register words addressed by index times four.
 */
package chd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map (index, byte address is index * 4)
  localparam int          ADDR_W    = 8;            // byte address width
  localparam logic [5:0]  CW0_IDX   = 6'h00;        // control word 0
  localparam logic [5:0]  CW7_IDX   = 6'h07;        // control word 7
  localparam logic [5:0]  STAT_IDX  = 6'h10;        // status word
  localparam logic [1:0]  RESP_OK   = 2'h0;         // axi okay
  localparam logic [1:0]  RESP_ERR  = 2'h2;         // axi slave error

  ////////////////////////////////////////////////////////////////////////////
  // field positions and reset values
  localparam int          BYP_BIT   = 6;            // cic bypass
  localparam int          DEC_LSB   = 7;            // decimation preload 12-7
  localparam int          SG_LSB    = 13;           // shift gain 16-13
  localparam int          SYNC_BIT  = 19;           // external sync enable
  localparam int          HB_LSB    = 15;           // halfband enables
  localparam logic [5:0]  DEC_RST   = 6'h03;        // preload R-1, R = 4
  localparam logic [3:0]  SG_RST    = 4'hF;         // shift gain at reset
  localparam logic [4:0]  HB_RST    = 5'h00;        // all halfbands bypassed
  localparam logic [3:0]  GAIN_MAX  = 4'hF;         // shifter saturation

  ////////////////////////////////////////////////////////////////////////////
  // cic geometry
  localparam int          IN_W      = 15;           // mixer sample width
  localparam int          ACC1_W    = 40;
  localparam int          ACC2_W    = 36;
  localparam int          ACC3_W    = 32;           // stages three to five

  ////////////////////////////////////////////////////////////////////////////
  // halfband coefficients, scaled by 2^17, even taps up to the centre
  localparam int          COEF_W    = 18;
  localparam int          COEF_FRAC = 17;
  localparam int          HB_N      = 5;
  localparam logic signed [COEF_W-1:0] HB_TAB [5][6] = '{
    '{-18'sd4103, 18'sd36868, 18'sd0, 18'sd0, 18'sd0, 18'sd0},
    '{18'sd777, -18'sd6427, 18'sd38416, 18'sd0, 18'sd0, 18'sd0},
    '{-18'sd171, 18'sd1623, -18'sd7936, 18'sd39250, 18'sd0, 18'sd0},
    '{18'sd50, -18'sd500, 18'sd2523, -18'sd9162, 18'sd39858, 18'sd0},
    '{-18'sd45, 18'sd329, -18'sd1332, 18'sd4004, -18'sd10745, 18'sd40556}
  };
  localparam logic signed [COEF_W-1:0] HB_MID [5] = '{
    18'sd65530, 18'sd65532, 18'sd65530, 18'sd65536, 18'sd65536
  };

  // coefficient of tap idx of stage (1..5), symmetric about the centre
  function automatic logic signed [COEF_W-1:0] hb_coef(input int stage,
                                                       input int idx);
    int c;
    int m;
    c = 2 * stage + 1;
    m = (idx > c) ? 2 * c - idx : idx;
    if (m == c) begin
      return HB_MID[stage-1];
    end else if (m % 2 == 1) begin
      return '0;
    end else begin
      return HB_TAB[stage-1][m/2];
    end
  endfunction : hb_coef

endpackage : chd_pkg

// ==== hdl/chd_halfband.sv ====
/*
 * one fixed halfband decimate-by-two stage with bypass.
 * assumes a sample stream with a one-cycle valid at most every cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module chd_halfband #(
  parameter int STAGE = 1,
  parameter int DW    = 24
) (
  // clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // control
  input  wire logic                 enable,
  // sample in
  input  wire logic                 in_valid,
  input  wire logic signed [DW-1:0] in_data,
  // sample out
  output var  logic                 out_valid,
  output var  logic signed [DW-1:0] out_data
);
  import chd_pkg::*;

  localparam int TAPS = 4 * STAGE + 3;             // 7, 11, 15, 19, 23
  localparam int AW   = DW + COEF_W + 5;            // accumulator width

  logic signed [DW-1:0] line      [TAPS-1];         // delay line
  logic signed [DW-1:0] next_line [TAPS-1];
  logic                 phase;                      // odd input seen
  logic                 next_phase;
  logic                 next_out_valid;
  logic signed [DW-1:0] next_out_data;
  logic signed [AW-1:0] acc;                        // filter sum

  ////////////////////////////////////////////////////////////////////////////
  // filter sum over the new sample and the delay line, decimation by two
  always_comb begin
    acc            = '0;
    next_line      = line;
    next_phase     = phase;
    next_out_valid = 1'b0;
    next_out_data  = out_data;
    acc = AW'(in_data) * AW'(hb_coef(STAGE, 0));
    for (int k = 1; k < TAPS; k++) begin
      acc = acc + AW'(line[k-1]) * AW'(hb_coef(STAGE, k));
    end
    if (!enable) begin
      // bypassed stage passes each sample straight on
      next_phase     = 1'b0;
      next_out_valid = in_valid;
      next_out_data  = in_data;
    end else if (in_valid) begin
      next_line[0] = in_data;
      for (int k = 1; k < TAPS - 1; k++) begin
        next_line[k] = line[k-1];
      end
      next_phase     = ~phase;
      next_out_valid = phase;
      next_out_data  = acc[COEF_FRAC +: DW];
    end
  end

  // registers only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < TAPS - 1; k++) begin
        line[k] <= '0;
      end
      phase     <= 1'b0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      line      <= next_line;
      phase     <= next_phase;
      out_valid <= next_out_valid;
      out_data  <= next_out_data;
    end
  end

endmodule : chd_halfband

`default_nettype wire

// ==== hdl/chd_decimator.sv ====
/*
 * cic and halfband decimation chain with an axi4-lite register slave.
 * assumes mixer samples synchronous to aclk and a single register master.
 */
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
// Functional notes
// - barrel shifter before first integrator, 6dB steps
// - 15-bit input, accumulators 40/36/32/32/32
// - shift gain four bits, 0 to 15
// - six-bit preload R-1 reloads counter
// - gain step adds 6dB per code
// - sync input loads counter when enabled
// - five halfband stages decimating by two
// - stages have 7,11,15,19,23 taps
// - per-stage enable bits, disabled stage bypassed
// - halfband decimation two to enabled count
// - fixed symmetric coefficients, zero odd taps except the centre
// - shift sum saturates at fifteen
// - gain step aligned with its sample
// - control word zero field layout
`timescale 1ns/1ps
`default_nettype none

module chd_decimator #(
  parameter int DW = 24                             // halfband data width
) (
  // clock and reset
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // axi4-lite write address
  input  wire logic [chd_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]                   s_axi_awprot,
  input  wire logic                         s_axi_awvalid,
  output var  logic                         s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output var  logic                         s_axi_wready,
  // axi4-lite write response
  output var  logic [1:0]                   s_axi_bresp,
  output var  logic                         s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  // axi4-lite read address
  input  wire logic [chd_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]                   s_axi_arprot,
  input  wire logic                         s_axi_arvalid,
  output var  logic                         s_axi_arready,
  // axi4-lite read data
  output var  logic [31:0]                  s_axi_rdata,
  output var  logic [1:0]                   s_axi_rresp,
  output var  logic                         s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  // mixer samples and front-end controls
  input  wire logic                         sample_valid,
  input  wire logic signed [chd_pkg::IN_W-1:0] sample_data,
  input  wire logic [2:0]                   input_gain_step,
  input  wire logic                         shared_sync_input,
  // decimated output toward the fir
  output var  logic                         out_valid,
  output var  logic signed [DW-1:0]         out_data
);
  import chd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // shift amount, sum saturates at the top code
  function automatic logic [3:0] sat_gain(input logic [3:0] sg,
                                          input logic [2:0] step);
    logic [4:0] s;
    s = {1'b0, sg} + {2'b00, step};
    return (s > {1'b0, GAIN_MAX}) ? GAIN_MAX : s[3:0];
  endfunction : sat_gain

  // byte-lane merge of a register write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // bus and configuration state
  logic [ADDR_W-1:0] aw_addr;                       // held write address
  logic              aw_held;                       // address taken
  logic [31:0]       w_data;                        // held write data
  logic [3:0]        w_strb;
  logic              w_held;                        // data taken
  logic [31:0]       cw0;                           // control word 0 image
  logic [31:0]       cw7;                           // control word 7 image
  logic [ADDR_W-1:0] next_aw_addr;
  logic              next_aw_held;
  logic [31:0]       next_w_data;
  logic [3:0]        next_w_strb;
  logic              next_w_held;
  logic [31:0]       next_cw0;
  logic [31:0]       next_cw7;
  logic              next_awready;
  logic              next_wready;
  logic [1:0]        next_bresp;
  logic              next_bvalid;
  logic              next_arready;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;
  logic              next_rvalid;
  logic [5:0]        rd_idx;                        // read word index
  logic [5:0]        wr_idx;                        // write word index

  // decoded fields
  logic [3:0]        shift_gain;                    // cic_shift_gain
  logic [5:0]        dec_preload;                   // R-1
  logic              cic_bypass;
  logic              sync_enable;                   // item_a
  logic [4:0]        hb_enable;

  assign shift_gain  = cw0[SG_LSB +: 4];
  assign dec_preload = cw0[DEC_LSB +: 6];
  assign cic_bypass  = cw0[BYP_BIT];
  assign sync_enable = cw0[SYNC_BIT];
  assign hb_enable   = cw7[HB_LSB +: HB_N];
  assign rd_idx      = s_axi_araddr[ADDR_W-1:2];
  assign wr_idx      = aw_addr[ADDR_W-1:2];

  ////////////////////////////////////////////////////////////////////////////
  // datapath state
  logic                     sh_valid;               // shifted sample valid
  logic signed [ACC1_W-1:0] sh_data;                // shifter output
  logic signed [ACC1_W-1:0] int1;                   // integrators
  logic signed [ACC2_W-1:0] int2;
  logic signed [ACC3_W-1:0] int3;
  logic signed [ACC3_W-1:0] int4;
  logic signed [ACC3_W-1:0] int5;
  logic signed [ACC3_W-1:0] dly [5];                // comb delays
  logic [5:0]               dec_cnt;                // decimation counter
  logic                     cic_valid;
  logic signed [DW-1:0]     cic_data;
  logic [7:0]               out_count;              // output samples seen
  logic                     next_sh_valid;
  logic signed [ACC1_W-1:0] next_sh_data;
  logic signed [ACC1_W-1:0] next_int1;
  logic signed [ACC2_W-1:0] next_int2;
  logic signed [ACC3_W-1:0] next_int3;
  logic signed [ACC3_W-1:0] next_int4;
  logic signed [ACC3_W-1:0] next_int5;
  logic signed [ACC3_W-1:0] next_dly [5];
  logic [5:0]               next_dec_cnt;
  logic                     next_cic_valid;
  logic signed [DW-1:0]     next_cic_data;
  logic [7:0]               next_out_count;
  logic signed [ACC3_W-1:0] comb;                   // comb chain value
  logic                     hb_valid [HB_N+1];      // chain taps
  logic signed [DW-1:0]     hb_data  [HB_N+1];

  ////////////////////////////////////////////////////////////////////////////
  // register slave: both write channels taken in either order
  always_comb begin
    next_aw_addr = aw_addr;
    next_aw_held = aw_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_w_held  = w_held;
    next_cw0     = cw0;
    next_cw7     = cw7;
    next_bresp   = s_axi_bresp;
    next_bvalid  = s_axi_bvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    next_rvalid  = s_axi_rvalid;
    // response handshakes
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    // capture address and data
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_addr = s_axi_awaddr;
      next_aw_held = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
      next_w_held = 1'b1;
    end
    // perform the write once both halves are held
    if (aw_held && w_held && !s_axi_bvalid) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OK;
      case (wr_idx)
        CW0_IDX: next_cw0 = merge(cw0, w_data, w_strb);
        CW7_IDX: next_cw7 = merge(cw7, w_data, w_strb);
        STAT_IDX: next_bresp = RESP_OK;   // read-only, write ignored
        default: next_bresp = RESP_ERR;   // unmapped
      endcase
    end
    // read: one cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OK;
      case (rd_idx)
        CW0_IDX: next_rdata = cw0;
        CW7_IDX: next_rdata = cw7;
        STAT_IDX: next_rdata = {16'h0000, out_count, 2'b00, dec_cnt};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = RESP_ERR;
        end
      endcase
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
    next_arready = !next_rvalid;
  end

  // registers only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr       <= '0;
      aw_held       <= 1'b0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      w_held        <= 1'b0;
      cw0           <= (32'(SG_RST) << SG_LSB) | (32'(DEC_RST) << DEC_LSB);
      cw7           <= 32'(HB_RST) << HB_LSB;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
      s_axi_rvalid  <= 1'b0;
    end else begin
      aw_addr       <= next_aw_addr;
      aw_held       <= next_aw_held;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      w_held        <= next_w_held;
      cw0           <= next_cw0;
      cw7           <= next_cw7;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bresp   <= next_bresp;
      s_axi_bvalid  <= next_bvalid;
      s_axi_arready <= next_arready;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
      s_axi_rvalid  <= next_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shifter, cic integrators, decimation counter and combs
  always_comb begin
    next_sh_valid  = sample_valid;
    next_sh_data   = sh_data;
    next_int1      = int1;
    next_int2      = int2;
    next_int3      = int3;
    next_int4      = int4;
    next_int5      = int5;
    next_dly       = dly;
    next_dec_cnt   = dec_cnt;
    next_cic_valid = 1'b0;
    next_cic_data  = cic_data;
    next_out_count = out_count;
    comb           = int5;
    // gain step sampled in the same cycle as its sample
    if (sample_valid) begin
      next_sh_data = ACC1_W'(sample_data) <<< sat_gain(shift_gain, input_gain_step);
    end
    if (sh_valid && cic_bypass) begin
      // bypass: sample goes straight on, scaled to the chain width
      next_cic_valid = 1'b1;
      next_cic_data  = sh_data[ACC1_W-1 -: DW];
    end else if (sh_valid) begin
      // integrators, each stage keeps the top bits of the one before
      next_int1 = int1 + sh_data;
      next_int2 = int2 + int1[ACC1_W-1 -: ACC2_W];
      next_int3 = int3 + int2[ACC2_W-1 -: ACC3_W];
      next_int4 = int4 + int3;
      next_int5 = int5 + int4;
      if (dec_cnt == 6'h00) begin
        // counter expired: run the combs and reload
        for (int k = 0; k < 5; k++) begin
          next_dly[k] = comb;
          comb        = comb - dly[k];
        end
        next_cic_valid = 1'b1;
        next_cic_data  = comb[ACC3_W-1 -: DW];
        next_dec_cnt   = dec_preload;
      end else begin
        next_dec_cnt = dec_cnt - 6'h01;
      end
    end
    // external sync takes precedence over counting
    if (sync_enable && shared_sync_input) begin
      next_dec_cnt = dec_preload;
    end
    if (out_valid) begin
      next_out_count = out_count + 8'h01;
    end
  end

  // registers only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh_valid  <= 1'b0;
      sh_data   <= '0;
      int1      <= '0;
      int2      <= '0;
      int3      <= '0;
      int4      <= '0;
      int5      <= '0;
      for (int k = 0; k < 5; k++) begin
        dly[k] <= '0;
      end
      dec_cnt   <= DEC_RST;
      cic_valid <= 1'b0;
      cic_data  <= '0;
      out_count <= 8'h00;
    end else begin
      sh_valid  <= next_sh_valid;
      sh_data   <= next_sh_data;
      int1      <= next_int1;
      int2      <= next_int2;
      int3      <= next_int3;
      int4      <= next_int4;
      int5      <= next_int5;
      dly       <= next_dly;
      dec_cnt   <= next_dec_cnt;
      cic_valid <= next_cic_valid;
      cic_data  <= next_cic_data;
      out_count <= next_out_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // halfband cascade, each enabled stage halves the rate
  assign hb_valid[0] = cic_valid;
  assign hb_data[0]  = cic_data;

  for (genvar s = 0; s < HB_N; s++) begin : g_hb
    chd_halfband #(
      .STAGE (s + 1),
      .DW    (DW)
    ) u_hb (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .enable    (hb_enable[s]),
      .in_valid  (hb_valid[s]),
      .in_data   (hb_data[s]),
      .out_valid (hb_valid[s+1]),
      .out_data  (hb_data[s+1])
    );
  end

  // last stage registers drive the outputs
  assign out_valid = hb_valid[HB_N];
  assign out_data  = hb_data[HB_N];

endmodule : chd_decimator

`default_nettype wire

// ==== testbench/chd_chk.sv ====
/* port checker for the decimation chain.
   assumes it is bound onto chd_decimator by the statement at the foot. */
`timescale 1ns/1ps
`default_nettype none

module chd_chk (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // sample stream
  input wire logic        sample_valid,
  input wire logic        out_valid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////
  // address and data taken at one edge
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // response held back one cycle, then raised
  sequence s_wr_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence

  a_wr_answer: assert property (s_wr_taken |=> s_wr_answer)
    else $error("write response not two edges after transfer");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one edge after address");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before bready");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed before rready");
  a_rd_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  a_wr_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_out_cause: assert property (out_valid |-> $past(sample_valid, 7))
    else $error("output without a sample seven edges earlier");
  a_reset_quiet: assert property (disable iff (1'b0)
    !aresetn |=> !out_valid && !s_axi_bvalid && !s_axi_rvalid)
    else $error("valid output during reset");
endmodule : chd_chk

bind chd_decimator chd_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sample_valid, .out_valid);

`default_nettype wire

// ==== testbench/chd_mixer_model.sv ====
/* mixer source and fir sink around the chain.
   assumes the bench starts bursts with a one-cycle start. */
`timescale 1ns/1ps
`default_nettype none

module chd_mixer_model (
  // bench control
  input wire logic               aclk,
  input wire logic               start,
  input wire logic [7:0]         n_samp,
  input wire logic signed [14:0] level,
  input wire logic [2:0]         step,
  // toward the chain
  output var logic               sample_valid,
  output var logic signed [14:0] sample_data,
  output var logic [2:0]         input_gain_step,
  // from the chain
  input wire logic               out_valid,
  input wire logic signed [23:0] out_data,
  output var logic [7:0]         n_out,
  output var logic signed [23:0] last_out
);
  logic [7:0] left;  // samples still to send

  initial begin
    {sample_valid, sample_data, input_gain_step, left, n_out, last_out} = '0;
  end

  // one sample a cycle; between samples the lines show inverted values
  always @(posedge aclk) begin
    sample_valid <= (left != 8'h00);
    sample_data <= (left != 8'h00) ? level : ~sample_data;
    input_gain_step <= (left != 8'h00) ? step : ~input_gain_step;
    left <= start ? n_samp : left - {7'h00, left != 8'h00};
    n_out <= start ? 8'h00 : n_out + {7'h00, out_valid};
    if (out_valid) last_out <= out_data;
  end
endmodule : chd_mixer_model

`default_nettype wire

// ==== testbench/chd_decimator_bench.sv ====
/* bench for the decimation chain: bus tasks and a table of bursts.
   assumes chd_mixer_model on the sample side. */
`timescale 1ns/1ps
`default_nettype none

module chd_decimator_bench;
  import chd_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sync, start;
  logic awready, wready, bvalid, arready, rvalid, svalid, ovalid;
  logic [7:0] awaddr, araddr, n_samp, n_out;
  logic [31:0] wdata, rdata, rd_d;
  logic [1:0] bresp, rresp, rd_r;
  logic [2:0] step, gstep;
  logic signed [14:0] level, sdata;
  logic signed [23:0] odata, last_out;
  int errors, n_tests, cyc, s;
  // bursts: cw0, cw7, samples, step; decimation kept at four or less
  logic [31:0] c0 [9] = '{32'h0001E180, 32'h0001E080, 32'h0009E080, 32'h0009E080,
    32'h0009E000, 32'h00094040, 32'h00094000, 32'h0009E000, 32'h00080000};
  logic [31:0] c7 [9] = '{32'h0, 32'h0, 32'h0, 32'h00028000, 32'h001F8000,
    32'h0, 32'h0, 32'h0, 32'h0};
  int ns [9] = '{16, 10, 10, 40, 64, 12, 12, 12, 12};
  logic [2:0] st [9] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h3, 3'h3, 3'h7};

  chd_decimator dut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sample_valid(svalid), .sample_data(sdata), .input_gain_step(gstep),
    .shared_sync_input(sync), .out_valid(ovalid), .out_data(odata));
  chd_mixer_model mix (.aclk, .start, .n_samp, .level, .step, .sample_valid(svalid),
    .sample_data(sdata), .input_gain_step(gstep), .out_valid(ovalid), .out_data(odata),
    .n_out, .last_out);

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk

  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    {awaddr, wdata, awvalid, wvalid} <= {a, d, 2'b11};
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && !bready) bready <= 1'b1;
    end while (!(bvalid && bready));
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    {araddr, arvalid} <= {a, 1'b1};
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid && rready));
    {rd_d, rd_r} = {rdata, rresp};
    rready <= 1'b0;
  endtask : rd

  // counter starts at 3 after reset; sync reloads it when enabled
  function automatic logic [31:0] n_expect(logic [31:0] w0, logic [31:0] w7, int n);
    int r;
    r = w0[12:7] + 1;
    n = w0[19] ? n / r : (n < 4 ? 0 : 1 + (n - 4) / r);
    return 32'(n >> $countones(w7[19:15]));
  endfunction : n_expect

  task automatic summarize;
    if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      summarize();
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, sync, start} = '0;
    {awaddr, araddr, n_samp, wdata, step, level} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd({CW0_IDX, 2'b00});
    chk("cw0 reset", rd_d, 32'h0001E180);
    @(posedge aclk);
    rd({CW7_IDX, 2'b00});
    chk("cw7 reset", rd_d, 32'h0);
    @(posedge aclk);
    rd(8'h20);
    chk("unmapped rresp", {30'h0, rd_r}, {30'h0, RESP_ERR});
    wr(8'h20, 32'h0);
    chk("unmapped bresp", {30'h0, bresp}, {30'h0, RESP_ERR});
    for (int i = 0; i < 9; i++) begin
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      wr({CW0_IDX, 2'b00}, c0[i]);
      @(posedge aclk);
      wr({CW7_IDX, 2'b00}, c7[i]);
      @(posedge aclk);
      {sync, start, step, n_samp, level} <= {2'b11, st[i], 8'(ns[i]), 15'h2000};
      @(posedge aclk);
      {sync, start} <= 2'b00;
      repeat (ns[i] + 12) @(posedge aclk);
      chk("outputs", {24'h0, n_out}, n_expect(c0[i], c7[i], ns[i]));
      s = c0[i][16:13] + st[i];
      if (s > 15) s = 15;
      if (c7[i] == 0 && c0[i][12:7] == 0) chk("level", {8'h0, last_out}, 32'h1 << (s - 3));
      rd({STAT_IDX, 2'b00});
      chk("status count", {24'h0, rd_d[15:8]}, n_expect(c0[i], c7[i], ns[i]));
    end
    summarize();
  end
endmodule : chd_decimator_bench

`default_nettype wire
